// >>> design/dual_fifo_reset_offset_program.v
// two opposite-direction fifos (a->b and b->a) with reset sequencing and offset setup
// assumes all pins are asynchronous to MCLK; port clocks are sampled, not used as clocks
`timescale 1ns/100ps
`include "dual_fifo_map.vh"
module dual_fifo_reset_offset_program #(
    parameter DATA_W = `FIFO_DATA_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter PTR_W = `FIFO_PTR_W,
    parameter STAGE_D = `STAGE_DEPTH,
    parameter STAGE_AW = `STAGE_AW,
    parameter LVL_W = `STAGE_LVL_W
) (
    input wire MCLK,
    input wire RST_B,
    input wire FIFO1_RESET_N,
    input wire FIFO2_RESET_N,
    input wire OFFSET_SEL_HI,
    input wire OFFSET_SEL_LO,
    input wire PORT_A_CLOCK,
    input wire PORT_A_SELECT_N,
    input wire PORT_A_DIR_SEL,
    input wire PORT_A_QUALIFY,
    input wire PORT_A_MAIL_SEL,
    input wire [DATA_W-1:0] PORT_A_BUS_IN,
    output wire [DATA_W-1:0] PORT_A_BUS_OUT,
    output wire PORT_A_BUS_OE_N,
    input wire PORT_B_CLOCK,
    input wire PORT_B_SELECT_N,
    input wire PORT_B_DIR_SEL,
    input wire PORT_B_QUALIFY,
    input wire PORT_B_MAIL_SEL,
    input wire [DATA_W-1:0] PORT_B_BUS_IN,
    output wire [DATA_W-1:0] PORT_B_BUS_OUT,
    output wire PORT_B_BUS_OE_N,
    output wire FIFO1_IN_READY_A,
    output wire FIFO1_ALMOST_FULL_A,
    output wire FIFO2_OUT_READY_A,
    output wire FIFO2_ALMOST_EMPTY_A,
    output wire FIFO2_IN_READY_B,
    output wire FIFO2_ALMOST_FULL_B,
    output wire FIFO1_OUT_READY_B,
    output wire FIFO1_ALMOST_EMPTY_B,
    output wire MAILBOX1_FLAG,
    output wire MAILBOX2_FLAG
);

function [7:0] preset_of;
    input hi;
    input lo;
    begin
        if (hi && lo)
            preset_of = `PRESET_BOTH;
        else if (hi)
            preset_of = `PRESET_HI;
        else
            preset_of = `PRESET_LO;
    end
endfunction

// two-stage synchronisers; nothing reads the first stage but the second
reg [`PIN_W-1:0] ctl_s1_r;
reg [`PIN_W-1:0] ctl_s2_r;
reg [2*DATA_W-1:0] bus_s1_r;
reg [2*DATA_W-1:0] bus_s2_r;
reg a_clk_d_r;
reg b_clk_d_r;
reg [1:0] rstn_d_r;
reg a_oe_n_r;
reg b_oe_n_r;
reg prog_r;
reg [1:0] prog_idx_r;
reg [7:0] fifo1_empty_offset_r;
reg [7:0] fifo1_full_offset_r;
reg [7:0] fifo2_empty_offset_r;
reg [7:0] fifo2_full_offset_r;

wire a_edge;
wire b_edge;
wire a_sel_n;
wire a_dir;
wire b_sel_n;
wire b_dir;
wire [1:0] wedge;
wire [1:0] redge;
wire [1:0] wq;
wire [1:0] rq;
wire [1:0] rstn;
wire [1:0] rise;
wire [1:0] hold;
wire [1:0] divert;
wire sel_any;
wire prog_wr;
wire [2*DATA_W-1:0] wdata;
wire [2*DATA_W-1:0] dout_w;
wire [15:0] empty_off;
wire [15:0] full_off;
wire [1:0] ir_w;
wire [1:0] or_w;
wire [1:0] ae_w;
wire [1:0] af_w;
wire [1:0] mb_w;

always @(posedge MCLK or negedge RST_B)
begin
    if (!RST_B)
    begin
        ctl_s1_r <= `PIN_IDLE;
        ctl_s2_r <= `PIN_IDLE;
        bus_s1_r <= {(2*DATA_W){1'b0}};
        bus_s2_r <= {(2*DATA_W){1'b0}};
        a_clk_d_r <= 1'b0;
        b_clk_d_r <= 1'b0;
        rstn_d_r <= 2'h0;
        a_oe_n_r <= 1'b1;
        b_oe_n_r <= 1'b1;
    end
    else
    begin
        // fifo resets are sampled like any pin, so they may move at any time
        ctl_s1_r <= {OFFSET_SEL_HI, OFFSET_SEL_LO, FIFO2_RESET_N, FIFO1_RESET_N,
                     PORT_B_MAIL_SEL, PORT_B_QUALIFY, PORT_B_DIR_SEL, PORT_B_SELECT_N,
                     PORT_B_CLOCK, PORT_A_MAIL_SEL, PORT_A_QUALIFY, PORT_A_DIR_SEL,
                     PORT_A_SELECT_N, PORT_A_CLOCK};
        ctl_s2_r <= ctl_s1_r;
        bus_s1_r <= {PORT_B_BUS_IN, PORT_A_BUS_IN};
        bus_s2_r <= bus_s1_r;
        a_clk_d_r <= ctl_s2_r[`PIN_A_CLK];
        b_clk_d_r <= ctl_s2_r[`PIN_B_CLK];
        rstn_d_r <= rstn;
        // drive only when selected and reading on that port
        a_oe_n_r <= a_sel_n | a_dir;
        b_oe_n_r <= b_sel_n | ~b_dir;
    end
end

// controls and data share the same two-stage delay as the clock they go with
assign a_edge = ctl_s2_r[`PIN_A_CLK] & ~a_clk_d_r;
assign b_edge = ctl_s2_r[`PIN_B_CLK] & ~b_clk_d_r;
assign a_sel_n = ctl_s2_r[`PIN_A_SEL_N];
assign a_dir = ctl_s2_r[`PIN_A_DIR];
assign b_sel_n = ctl_s2_r[`PIN_B_SEL_N];
assign b_dir = ctl_s2_r[`PIN_B_DIR];
assign wq[0] = ~a_sel_n & a_dir & ctl_s2_r[`PIN_A_QUAL] & ~ctl_s2_r[`PIN_A_MAIL];
assign rq[1] = ~a_sel_n & ~a_dir & ctl_s2_r[`PIN_A_QUAL] & ~ctl_s2_r[`PIN_A_MAIL];
assign wq[1] = ~b_sel_n & ~b_dir & ctl_s2_r[`PIN_B_QUAL] & ~ctl_s2_r[`PIN_B_MAIL];
assign rq[0] = ~b_sel_n & b_dir & ctl_s2_r[`PIN_B_QUAL] & ~ctl_s2_r[`PIN_B_MAIL];
assign wedge = {b_edge, a_edge};
assign redge = {a_edge, b_edge};
assign rstn = {ctl_s2_r[`PIN_FIFO2_RESET_N_N], ctl_s2_r[`PIN_FIFO1_RESET_N_N]};
assign rise = rstn & ~rstn_d_r;
assign sel_any = ctl_s2_r[`PIN_SEL_HI] | ctl_s2_r[`PIN_SEL_LO];
assign wdata = bus_s2_r;
assign hold = {prog_r, 1'b0};
assign divert = {1'b0, prog_r};
// only a fully qualified, accepted fifo1 write steps the sequence
assign prog_wr = prog_r & a_edge & wq[0] & ir_w[0] & rstn[0];
assign empty_off = {fifo2_empty_offset_r, fifo1_empty_offset_r};
assign full_off = {fifo2_full_offset_r, fifo1_full_offset_r};

always @(posedge MCLK or negedge RST_B)
begin
    if (!RST_B)
    begin
        prog_r <= 1'b0;
        prog_idx_r <= `PROG_F1_FULL;
        fifo1_empty_offset_r <= `OFFSET_INIT;
        fifo1_full_offset_r <= `OFFSET_INIT;
        fifo2_empty_offset_r <= `OFFSET_INIT;
        fifo2_full_offset_r <= `OFFSET_INIT;
    end
    else
    begin
        // each fifo takes its preset on its own release
        if (rise[0] && sel_any)
        begin
            fifo1_empty_offset_r <= preset_of(ctl_s2_r[`PIN_SEL_HI], ctl_s2_r[`PIN_SEL_LO]);
            fifo1_full_offset_r <= preset_of(ctl_s2_r[`PIN_SEL_HI], ctl_s2_r[`PIN_SEL_LO]);
        end
        if (rise[1] && sel_any)
        begin
            fifo2_empty_offset_r <= preset_of(ctl_s2_r[`PIN_SEL_HI], ctl_s2_r[`PIN_SEL_LO]);
            fifo2_full_offset_r <= preset_of(ctl_s2_r[`PIN_SEL_HI], ctl_s2_r[`PIN_SEL_LO]);
        end
        // a release with both selects low starts programming
        if ((rise[0] || rise[1]) && !sel_any)
        begin
            prog_r <= 1'b1;
            prog_idx_r <= `PROG_F1_FULL;
        end
        else if (prog_wr)
        begin
            // low eight bus bits, msb on line 7; range is the writer's job
            case (prog_idx_r)
                `PROG_F1_FULL: fifo1_full_offset_r <= wdata[7:0];
                `PROG_F1_EMPTY: fifo1_empty_offset_r <= wdata[7:0];
                `PROG_F2_FULL: fifo2_full_offset_r <= wdata[7:0];
                default: fifo2_empty_offset_r <= wdata[7:0];
            endcase
            prog_idx_r <= prog_idx_r + 2'h1;
            if (prog_idx_r == `PROG_F2_EMPTY)
                prog_r <= 1'b0;
        end
    end
end

// index 0: fifo1, written at port a, read at port b; index 1 the reverse
genvar i;
generate
for (i = 0; i < 2; i = i + 1)
begin : g_dir
    reg [DATA_W-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wptr_r;
    reg [PTR_W-1:0] rptr_r;
    reg [DATA_W-1:0] oreg_r;
    reg or_r;
    reg ir_r;
    reg ae_r;
    reg af_r;
    reg mb_r;
    reg [1:0] or_cnt_r;
    reg [1:0] ir_cnt_r;
    wire [PTR_W-1:0] ram_cnt;
    wire stg_in_rdy;
    wire stg_out_vld;
    wire stg_out_rdy;
    wire [DATA_W-1:0] stg_out;
    wire [LVL_W-1:0] stg_lvl;
    wire wr_take;
    wire [PTR_W:0] fill;
    wire [PTR_W:0] fill_nx;

    assign ram_cnt = wptr_r - rptr_r;
    // writes are dropped while full or during programming diversion
    assign wr_take = wedge[i] & wq[i] & ir_r & stg_in_rdy & rstn[i] & ~divert[i];
    assign stg_out_rdy = (ram_cnt < DEPTH) & rstn[i];
    // count includes staged words and the word in the output register
    assign fill = {1'b0, ram_cnt} + {{(PTR_W+1-LVL_W){1'b0}}, stg_lvl}
                  + {{PTR_W{1'b0}}, or_r};
    assign fill_nx = fill + {{PTR_W{1'b0}}, wr_take};

    stage_fifo #(
        .W(DATA_W),
        .D(STAGE_D),
        .AW(STAGE_AW),
        .LVL_W(LVL_W)
    ) u_stage (
        .clk(MCLK),
        .rst_b(RST_B),
        .clr(~rstn[i]),
        .in_valid(wr_take),
        .in_ready(stg_in_rdy),
        .in_data(wdata[i*DATA_W +: DATA_W]),
        .out_valid(stg_out_vld),
        .out_ready(stg_out_rdy),
        .out_data(stg_out),
        .level(stg_lvl)
    );

    always @(posedge MCLK)
    begin
        if (stg_out_vld && stg_out_rdy)
            mem[wptr_r[PTR_W-2:0]] <= stg_out;
    end

    // write side: pointer, input-ready, almost-full
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            wptr_r <= {PTR_W{1'b0}};
            ir_r <= 1'b0;
            ir_cnt_r <= 2'h0;
            af_r <= 1'b1;
        end
        else if (!rstn[i])
        begin
            wptr_r <= {PTR_W{1'b0}};
            ir_r <= 1'b0;
            ir_cnt_r <= 2'h0;
            af_r <= 1'b1;
        end
        else
        begin
            if (stg_out_vld && stg_out_rdy)
                wptr_r <= wptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
            if (wedge[i])
            begin
                if (ir_cnt_r != `IR_SAT)
                    ir_cnt_r <= ir_cnt_r + 2'h1;
                // second write-port edge after release
                ir_r <= (ir_cnt_r >= `IR_LAT) && !hold[i] && (fill_nx < DEPTH);
                // low once count reaches depth minus offset
                af_r <= (fill_nx < (DEPTH - full_off[i*8 +: 8]));
            end
        end
    end

    // read side: pointer, output register, output-ready, almost-empty
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rptr_r <= {PTR_W{1'b0}};
            oreg_r <= {DATA_W{1'b0}};
            or_r <= 1'b0;
            or_cnt_r <= 2'h0;
            ae_r <= 1'b0;
        end
        else if (!rstn[i])
        begin
            rptr_r <= {PTR_W{1'b0}};
            or_r <= 1'b0;
            or_cnt_r <= 2'h0;
            ae_r <= 1'b0;
        end
        else if (redge[i])
        begin
            // flags move only on read-port edges
            ae_r <= (fill > {2'h0, empty_off[i*8 +: 8]});
            if (or_r)
            begin
                if (rq[i])
                begin
                    if (ram_cnt != {PTR_W{1'b0}})
                    begin
                        oreg_r <= mem[rptr_r[PTR_W-2:0]];
                        rptr_r <= rptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
                    end
                    else
                        or_r <= 1'b0;
                end
            end
            else if (ram_cnt != {PTR_W{1'b0}})
            begin
                // the third edge loads the word and raises the flag
                if (or_cnt_r == `OR_LAT)
                begin
                    oreg_r <= mem[rptr_r[PTR_W-2:0]];
                    rptr_r <= rptr_r + {{(PTR_W-1){1'b0}}, 1'b1};
                    or_r <= 1'b1;
                    or_cnt_r <= 2'h0;
                end
                else
                    or_cnt_r <= or_cnt_r + 2'h1;
            end
            else
                or_cnt_r <= 2'h0;
        end
    end

    // mailbox transfers live elsewhere; here the flag only marks empty on reset
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            mb_r <= 1'b1;
        else if (!rstn[i])
            mb_r <= 1'b1;
    end

    assign dout_w[i*DATA_W +: DATA_W] = oreg_r;
    assign ir_w[i] = ir_r;
    assign or_w[i] = or_r;
    assign ae_w[i] = ae_r;
    assign af_w[i] = af_r;
    assign mb_w[i] = mb_r;
end
endgenerate

assign PORT_B_BUS_OUT = dout_w[DATA_W-1:0];
assign PORT_A_BUS_OUT = dout_w[2*DATA_W-1:DATA_W];
assign PORT_A_BUS_OE_N = a_oe_n_r;
assign PORT_B_BUS_OE_N = b_oe_n_r;
assign FIFO1_IN_READY_A = ir_w[0];
assign FIFO1_ALMOST_FULL_A = af_w[0];
assign FIFO1_OUT_READY_B = or_w[0];
assign FIFO1_ALMOST_EMPTY_B = ae_w[0];
assign FIFO2_IN_READY_B = ir_w[1];
assign FIFO2_ALMOST_FULL_B = af_w[1];
assign FIFO2_OUT_READY_A = or_w[1];
assign FIFO2_ALMOST_EMPTY_A = ae_w[1];
assign MAILBOX1_FLAG = mb_w[0];
assign MAILBOX2_FLAG = mb_w[1];

endmodule // dual_fifo_reset_offset_program

// >>> design/dual_fifo_map.vh
// constants for the two-way fifo pair: sizes, presets, flag latencies, pin slots
// included by the fifo pair core; holds definitions only
`ifndef DUAL_FIFO_MAP_VH
`define DUAL_FIFO_MAP_VH

`define FIFO_DATA_W 36
`define FIFO_DEPTH 256
`define FIFO_PTR_W 9
`define STAGE_DEPTH 4
`define STAGE_AW 2
`define STAGE_LVL_W 3

// almost-flag offset presets and the value held before any fifo reset
`define PRESET_BOTH 8'h40
`define PRESET_HI 8'h10
`define PRESET_LO 8'h08
`define OFFSET_INIT 8'h08

// programming order of the four offset writes
`define PROG_F1_FULL 2'h0
`define PROG_F1_EMPTY 2'h1
`define PROG_F2_FULL 2'h2
`define PROG_F2_EMPTY 2'h3

// port-clock edge counts: output-ready on the third edge, input-ready on the second
`define OR_LAT 2'h2
`define IR_LAT 2'h1
`define IR_SAT 2'h2

// slots of the synchronised control pins
`define PIN_A_CLK 0
`define PIN_A_SEL_N 1
`define PIN_A_DIR 2
`define PIN_A_QUAL 3
`define PIN_A_MAIL 4
`define PIN_B_CLK 5
`define PIN_B_SEL_N 6
`define PIN_B_DIR 7
`define PIN_B_QUAL 8
`define PIN_B_MAIL 9
`define PIN_FIFO1_RESET_N_N 10
`define PIN_FIFO2_RESET_N_N 11
`define PIN_SEL_LO 12
`define PIN_SEL_HI 13
`define PIN_W 14
// select pins idle high, everything else low (fifo resets asserted)
`define PIN_IDLE 14'h0042

`endif

// >>> design/stage_fifo.v
// small first-in first-out stage with valid/ready on both sides
// assumes depth is a power of two equal to 2**AW; clr empties it synchronously
`timescale 1ns/100ps
`include "dual_fifo_map.vh"
module stage_fifo #(
    parameter W = `FIFO_DATA_W,
    parameter D = `STAGE_DEPTH,
    parameter AW = `STAGE_AW,
    parameter LVL_W = `STAGE_LVL_W
) (
    input wire clk,
    input wire rst_b,
    input wire clr,
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data,
    output wire [LVL_W-1:0] level
);

reg [W-1:0] mem [0:D-1];
reg [AW-1:0] wp_r;
reg [AW-1:0] rp_r;
reg [LVL_W-1:0] cnt_r;
wire push;
wire pop;

assign in_ready = (cnt_r != D[LVL_W-1:0]);
assign out_valid = (cnt_r != {LVL_W{1'b0}});
assign out_data = mem[rp_r];
assign level = cnt_r;
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

always @(posedge clk)
begin
    if (push)
        mem[wp_r] <= in_data;
end

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {LVL_W{1'b0}};
    end
    else if (clr)
    begin
        wp_r <= {AW{1'b0}};
        rp_r <= {AW{1'b0}};
        cnt_r <= {LVL_W{1'b0}};
    end
    else
    begin
        if (push)
            wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
        if (pop)
            rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
        if (push && !pop)
            cnt_r <= cnt_r + {{(LVL_W-1){1'b0}}, 1'b1};
        else if (pop && !push)
            cnt_r <= cnt_r - {{(LVL_W-1){1'b0}}, 1'b1};
    end
end

endmodule // stage_fifo

// >>> verif/dual_fifo_reset_offset_program_checker.sv
// assertions on the fifo pair's pins: flag timing, output enables, reset levels
// assumes port clocks of eight MCLK periods and resets held for several MCLK
`timescale 1ns/100ps
module fifo_pair_checker (
    input wire MCLK,
    input wire RST_B,
    input wire FIFO1_RESET_N,
    input wire FIFO2_RESET_N,
    input wire OFFSET_SEL_HI,
    input wire OFFSET_SEL_LO,
    input wire PORT_A_SELECT_N,
    input wire PORT_A_DIR_SEL,
    input wire PORT_A_BUS_OE_N,
    input wire PORT_B_CLOCK,
    input wire PORT_B_DIR_SEL,
    input wire PORT_B_BUS_OE_N,
    input wire FIFO1_IN_READY_A,
    input wire FIFO1_ALMOST_FULL_A,
    input wire FIFO1_OUT_READY_B,
    input wire FIFO1_ALMOST_EMPTY_B,
    input wire FIFO2_IN_READY_B,
    input wire FIFO2_ALMOST_FULL_B,
    input wire FIFO2_ALMOST_EMPTY_A,
    input wire MAILBOX1_FLAG,
    input wire MAILBOX2_FLAG
);
    reg [1:0] b_smp_r;
    reg [3:0] b_age_r;
    // cycles since port b clock was last seen rising; saturates
    always @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            b_smp_r <= 2'h0;
            b_age_r <= 4'hf;
        end
        else
        begin
            b_smp_r <= {b_smp_r[0], PORT_B_CLOCK};
            b_age_r <= (b_smp_r == 2'h1) ? 4'h0 : ((b_age_r == 4'hf) ? b_age_r : b_age_r + 4'h1);
        end
    end
    default clocking dflt @(posedge MCLK); endclocking
    default disable iff (!RST_B);
    sequence rel1;
        $rose(FIFO1_RESET_N) ##1 FIFO1_RESET_N [*4];
    endsequence
    sequence rel2_preset;
        $rose(FIFO2_RESET_N) && (OFFSET_SEL_HI || OFFSET_SEL_LO) ##1 FIFO2_RESET_N [*4];
    endsequence
    a_ready_b_edge: assert property ($rose(FIFO1_OUT_READY_B) |-> b_age_r <= 4'h5)
        else $error("out-ready b rose away from a port b edge");
    a_reset1_levels: assert property ((!FIFO1_RESET_N) [*6] |-> !FIFO1_IN_READY_A
        && !FIFO1_OUT_READY_B && !FIFO1_ALMOST_EMPTY_B && FIFO1_ALMOST_FULL_A)
        else $error("fifo1 flags wrong during reset");
    a_reset2_levels: assert property ((!FIFO2_RESET_N) [*6] |-> !FIFO2_IN_READY_B
        && !FIFO2_ALMOST_EMPTY_A && FIFO2_ALMOST_FULL_B)
        else $error("fifo2 flags wrong during reset");
    a_mailbox_empty: assert property (MAILBOX1_FLAG && MAILBOX2_FLAG)
        else $error("mailbox flag low");
    a_port_a_float: assert property (PORT_A_DIR_SEL [*5] |-> PORT_A_BUS_OE_N)
        else $error("port a driven while write selected");
    a_port_a_drive: assert property ((!PORT_A_SELECT_N && !PORT_A_DIR_SEL) [*5]
        |-> !PORT_A_BUS_OE_N)
        else $error("port a not driven while read selected");
    a_port_b_float: assert property ((!PORT_B_DIR_SEL) [*5] |-> PORT_B_BUS_OE_N)
        else $error("port b driven while write selected");
    a_in_ready_two: assert property (rel1 |-> !FIFO1_IN_READY_A [*4] ##[1:20]
        FIFO1_IN_READY_A)
        else $error("fifo1 input ready timing after reset");
    a_preset_ready: assert property (rel2_preset |-> ##[4:24] FIFO2_IN_READY_B)
        else $error("fifo2 input ready missing after preset reset");
endmodule // fifo_pair_checker
bind dual_fifo_reset_offset_program fifo_pair_checker i_chk (.MCLK, .RST_B, .FIFO1_RESET_N,
    .FIFO2_RESET_N, .OFFSET_SEL_HI, .OFFSET_SEL_LO, .PORT_A_SELECT_N, .PORT_A_DIR_SEL,
    .PORT_A_BUS_OE_N, .PORT_B_CLOCK, .PORT_B_DIR_SEL, .PORT_B_BUS_OE_N, .FIFO1_IN_READY_A,
    .FIFO1_ALMOST_FULL_A, .FIFO1_OUT_READY_B, .FIFO1_ALMOST_EMPTY_B, .FIFO2_IN_READY_B,
    .FIFO2_ALMOST_FULL_B, .FIFO2_ALMOST_EMPTY_A, .MAILBOX1_FLAG, .MAILBOX2_FLAG);

// >>> verif/far_ports.sv
// far-side model: one processor on each port, each with its free-running port clock
// assumes one caller per port task; requests change only on the port clock's falling edge
`timescale 1ns/100ps
module far_ports (
    output reg a_clk,
    output reg a_sel_n,
    output reg a_dir,
    output reg a_qual,
    output reg a_mail,
    output reg [35:0] a_din,
    input wire [35:0] a_dout,
    output reg b_clk,
    output reg b_sel_n,
    output reg b_dir,
    output reg b_qual,
    output reg b_mail,
    output reg [35:0] b_din,
    input wire [35:0] b_dout
);
    initial
    begin
        {a_clk, a_sel_n, a_dir, a_qual, a_mail, a_din} = {5'h08, 36'h0};
        {b_clk, b_sel_n, b_dir, b_qual, b_mail, b_din} = {5'h08, 36'h0};
    end
    always #100 a_clk = ~a_clk;
    // port b runs at the same rate, its edges 30 ns behind those of port a
    initial #30 forever #100 b_clk = ~b_clk;
    task port_a(input logic wr, input logic mail, input logic [35:0] d, output logic [35:0] q);
    begin
        @(negedge a_clk);
        {a_sel_n, a_dir, a_qual, a_mail, a_din} = {1'b0, wr, 1'b1, mail, d};
        @(posedge a_clk);
        q = a_dout;
        @(negedge a_clk);
        // released lines show a changed value, not the last one
        {a_sel_n, a_qual, a_din} = {1'b1, 1'b0, ~d};
    end
    endtask
    task port_b(input logic wr, input logic mail, input logic [35:0] d, output logic [35:0] q);
    begin
        @(negedge b_clk);
        {b_sel_n, b_dir, b_qual, b_mail, b_din} = {1'b0, ~wr, 1'b1, mail, d};
        @(posedge b_clk);
        q = b_dout;
        @(negedge b_clk);
        {b_sel_n, b_qual, b_din} = {1'b1, 1'b0, ~d};
    end
    endtask
endmodule // far_ports

// >>> verif/dual_fifo_reset_offset_program_bench.sv
// self-checking bench for the fifo pair: resets, presets, fill and drain, offset programming
// assumes the far-side model far_ports and the bound pin checker
`timescale 1ns/100ps
module dual_fifo_reset_offset_program_bench;
    reg mclk = 1'b0;
    reg rst_b = 1'b0;
    reg f1_rst_n = 1'b0;
    reg f2_rst_n = 1'b0;
    reg sel_hi = 1'b0;
    reg sel_lo = 1'b0;
    wire a_clk, a_sel_n, a_dir, a_qual, a_mail, a_oe_n, b_clk, b_sel_n, b_dir, b_qual, b_mail;
    wire b_oe_n, f1_in, f1_af, f2_out, f2_ae, f2_in, f2_af, f1_out, f1_ae, mail1, mail2;
    wire [35:0] a_din, a_dout, b_din, b_dout;
    integer errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    logic [35:0] q;
    always #12.5 mclk = ~mclk;
    dual_fifo_reset_offset_program i_dut (.MCLK(mclk), .RST_B(rst_b), .FIFO1_RESET_N(f1_rst_n),
        .FIFO2_RESET_N(f2_rst_n), .OFFSET_SEL_HI(sel_hi), .OFFSET_SEL_LO(sel_lo),
        .PORT_A_CLOCK(a_clk), .PORT_A_SELECT_N(a_sel_n), .PORT_A_DIR_SEL(a_dir),
        .PORT_A_QUALIFY(a_qual), .PORT_A_MAIL_SEL(a_mail), .PORT_A_BUS_IN(a_din),
        .PORT_A_BUS_OUT(a_dout), .PORT_A_BUS_OE_N(a_oe_n), .PORT_B_CLOCK(b_clk),
        .PORT_B_SELECT_N(b_sel_n), .PORT_B_DIR_SEL(b_dir), .PORT_B_QUALIFY(b_qual),
        .PORT_B_MAIL_SEL(b_mail), .PORT_B_BUS_IN(b_din), .PORT_B_BUS_OUT(b_dout),
        .PORT_B_BUS_OE_N(b_oe_n), .FIFO1_IN_READY_A(f1_in), .FIFO1_ALMOST_FULL_A(f1_af),
        .FIFO2_OUT_READY_A(f2_out), .FIFO2_ALMOST_EMPTY_A(f2_ae), .FIFO2_IN_READY_B(f2_in),
        .FIFO2_ALMOST_FULL_B(f2_af), .FIFO1_OUT_READY_B(f1_out), .FIFO1_ALMOST_EMPTY_B(f1_ae),
        .MAILBOX1_FLAG(mail1), .MAILBOX2_FLAG(mail2));
    far_ports i_far (.a_clk(a_clk), .a_sel_n(a_sel_n), .a_dir(a_dir), .a_qual(a_qual),
        .a_mail(a_mail), .a_din(a_din), .a_dout(a_dout), .b_clk(b_clk), .b_sel_n(b_sel_n),
        .b_dir(b_dir), .b_qual(b_qual), .b_mail(b_mail), .b_din(b_din), .b_dout(b_dout));
    task chk(input string n, input logic [35:0] e, input logic [35:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e)
        begin
            errors = errors + 1;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    end
    endtask
    // flags follow port edges with a few MCLK of lag; eight port periods covers it
    task settle;
    begin
        repeat (64) @(posedge mclk);
        #2;
    end
    endtask
    task fifo_rst(input logic r1, input logic r2, input logic hi, input logic lo);
    begin
        @(posedge mclk);
        #2;
        sel_hi = hi;
        sel_lo = lo;
        if (r1)
            f1_rst_n = 1'b0;
        if (r2)
            f2_rst_n = 1'b0;
        repeat (48) @(posedge mclk);
        // release just after a port a edge so the edges that follow can be counted
        @(posedge a_clk);
        @(posedge mclk);
        #2;
        if (r1)
            f1_rst_n = 1'b1;
        if (r2)
            f2_rst_n = 1'b1;
    end
    endtask
    task t_release;
    begin
        fifo_rst(1'b1, 1'b0, 1'b1, 1'b1);
        @(posedge a_clk);
        repeat (6) @(posedge mclk);
        chk("in ready a one edge", 1'b0, f1_in);
        @(posedge a_clk);
        repeat (6) @(posedge mclk);
        chk("in ready a two edges", 1'b1, f1_in);
    end
    endtask
    task t_fill;
        integer i;
    begin
        for (i = 1; i <= 257; i = i + 1)
        begin
            i_far.port_a(1'b1, 1'b0, {4'h0, i}, q);
            if (i == 1)
            begin
                repeat (2) @(posedge b_clk);
                chk("out ready b early", 1'b0, f1_out);
                @(posedge b_clk);
                repeat (6) @(posedge mclk);
                chk("out ready b third edge", 1'b1, f1_out);
            end
            if (i == 64 || i == 65 || i == 191 || i == 192 || i == 255 || i == 256)
            begin
                settle;
                chk("almost empty b", i > 64, f1_ae);
                chk("almost full a", i < 192, f1_af);
                chk("in ready a", i < 256, f1_in);
            end
        end
        for (i = 1; i <= 256; i = i + 1)
        begin
            i_far.port_b(1'b0, 1'b0, 36'h0, q);
            chk("fifo1 word", {4'h0, i}, q);
        end
        settle;
        chk("out ready b drained", 1'b0, f1_out);
    end
    endtask
    task t_presets;
        integer k;
        logic [7:0] n;
    begin
        for (k = 0; k < 3; k = k + 1)
        begin
            n = (k == 0) ? 8'h40 : ((k == 1) ? 8'h10 : 8'h08);
            fifo_rst(1'b0, 1'b1, k < 2, k != 1);
            settle;
            chk("in ready b preset", 1'b1, f2_in);
            repeat (n) i_far.port_b(1'b1, 1'b0, {28'h0, n}, q);
            settle;
            chk("almost empty a at offset", 1'b0, f2_ae);
            i_far.port_b(1'b1, 1'b0, {28'h0, n}, q);
            settle;
            chk("almost empty a past offset", 1'b1, f2_ae);
        end
        chk("in ready a kept", 1'b1, f1_in);
        chk("out ready a filled", 1'b1, f2_out);
        i_far.port_a(1'b0, 1'b0, 36'h0, q);
        chk("fifo2 word", 36'h8, q);
    end
    endtask
    task t_program;
    begin
        fifo_rst(1'b1, 1'b1, 1'b0, 1'b0);
        settle;
        i_far.port_a(1'b1, 1'b0, 36'hfc, q);
        i_far.port_a(1'b1, 1'b1, 36'h5, q);
        i_far.port_a(1'b1, 1'b0, 36'hf03, q);
        i_far.port_a(1'b1, 1'b0, 36'hfc, q);
        settle;
        chk("in ready b programming", 1'b0, f2_in);
        i_far.port_a(1'b1, 1'b0, 36'h1, q);
        settle;
        chk("in ready b programmed", 1'b1, f2_in);
        chk("out ready b none stored", 1'b0, f1_out);
        repeat (3) i_far.port_a(1'b1, 1'b0, 36'h7, q);
        settle;
        chk("almost empty b three", 1'b0, f1_ae);
        chk("almost full a three", 1'b1, f1_af);
        i_far.port_a(1'b1, 1'b0, 36'h7, q);
        settle;
        chk("almost empty b four", 1'b1, f1_ae);
        chk("almost full a four", 1'b0, f1_af);
        i_far.port_b(1'b1, 1'b0, 36'h9, q);
        settle;
        chk("almost empty a one", 1'b0, f2_ae);
        repeat (3) i_far.port_b(1'b1, 1'b0, 36'h9, q);
        settle;
        chk("almost empty a four", 1'b1, f2_ae);
        chk("almost full b four", 1'b0, f2_af);
    end
    endtask
    task results;
    begin
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        repeat (16) @(posedge mclk);
        #2;
        rst_b = 1'b1;
        settle;
        chk("in ready a in reset", 1'b0, f1_in);
        chk("out ready b in reset", 1'b0, f1_out);
        chk("almost empty b in reset", 1'b0, f1_ae);
        chk("almost full a in reset", 1'b1, f1_af);
        chk("mailbox flags", 2'h3, {mail1, mail2});
        chk("out ready a in reset", 1'b0, f2_out);
        t_release;
        t_fill;
        t_presets;
        t_program;
        results;
    end
    // the whole run needs about 12000 MCLK
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 40000)
        begin
            errors = errors + 1;
            results;
        end
    end
endmodule // dual_fifo_reset_offset_program_bench
